//--- rtl/npf_payload_formatter.sv
// Payload formatter: snapshots field inputs into a packet payload and streams it out byte by byte
`default_nettype none
module npf_payload_formatter #(
	parameter int ADDR_W = 8,
	parameter bit ANT_FLAGS_EN = 1'b1,
	parameter bit GNSS2_EN = 1'b1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic req_valid,
	input wire logic [7:0] req_id,
	output logic req_ready,
	input wire npf_pkg::npf_raw_sensor_s raw_sensor,
	input wire npf_pkg::npf_gnss_s raw_gnss,
	input wire npf_pkg::npf_sats_s sats,
	input wire npf_pkg::npf_pos_s geodetic,
	input wire npf_pkg::npf_pos_s ecef,
	input wire npf_pkg::npf_grid_s grid,
	input wire npf_pkg::npf_ned_s ned_vel,
	output logic out_valid,
	input wire logic out_ready,
	output npf_pkg::npf_beat_s out_beat,
	output logic [7:0] out_len,
	output logic irq
);
	import npf_pkg::*;

	// Places up to eight bytes of a value, least significant byte at the lowest offset
	function automatic npf_pay_t put(npf_pay_t v, int off, logic [63:0] x, int nbytes);
		for (int i = 0; i < 8; i++) begin
			if (i < nbytes) begin
				v[(off + i) * 8 +: 8] = x[i * 8 +: 8];
			end
		end
		return v;
	endfunction

	// Length of a known packet; zero marks an identifier this block does not produce
	function automatic logic [7:0] len_of(logic [7:0] id);
		case (id)
			ID_RAW_SENSOR: len_of = LEN_RAW_SENSOR;
			ID_RAW_GNSS: len_of = LEN_RAW_GNSS;
			ID_SATS: len_of = LEN_SATS;
			ID_GEODETIC: len_of = LEN_GEODETIC;
			ID_ECEF: len_of = LEN_ECEF;
			ID_GRID: len_of = LEN_GRID;
			ID_NED_VEL: len_of = LEN_NED_VEL;
			default: len_of = 8'h00;
		endcase
	endfunction

	// Receiver status word; variant parameters force inapplicable flags low
	function automatic logic [15:0] gnss_status(npf_gnss_flags_s f);
		logic [15:0] w;
		w = '0;
		w[2:0] = f.fix;
		w[3] = f.doppler_valid;
		w[4] = f.time_valid;
		w[5] = f.ext_rx;
		w[6] = f.tilt_valid;
		w[7] = f.heading_valid;
		w[8] = f.float_amb;
		w[9] = 1'b0;
		w[10] = f.ant1_disc & ANT_FLAGS_EN;
		w[11] = f.ant2_disc & ANT_FLAGS_EN;
		w[12] = f.ant1_short & ANT_FLAGS_EN;
		w[13] = f.ant2_short & ANT_FLAGS_EN;
		w[14] = f.gnss1_fail;
		w[15] = f.gnss2_fail & GNSS2_EN;
		return w;
	endfunction

	// Builds the whole payload for one identifier; unused tail bytes stay zero
	function automatic npf_pay_t build(logic [7:0] id);
		npf_pay_t p;
		p = '0;
		case (id)
			ID_RAW_SENSOR: begin
				for (int i = 0; i < 3; i++) begin
					p = put(p, RS_OFF_ACC + i * F32_STEP, {32'h0, raw_sensor.acc[i]}, F32_STEP);
					p = put(p, RS_OFF_GYR + i * F32_STEP, {32'h0, raw_sensor.gyr[i]}, F32_STEP);
					p = put(p, RS_OFF_MAG + i * F32_STEP, {32'h0, raw_sensor.mag[i]}, F32_STEP);
				end
				p = put(p, RS_OFF_IMU_T, {32'h0, raw_sensor.imu_temp}, F32_STEP);
				p = put(p, RS_OFF_PRES, {32'h0, raw_sensor.pressure}, F32_STEP);
				p = put(p, RS_OFF_PRES_T, {32'h0, raw_sensor.pres_temp}, F32_STEP);
			end
			ID_RAW_GNSS: begin
				// Receiver values go out untouched: no antenna offset or lever-arm step here
				p = put(p, GN_OFF_SEC, {32'h0, raw_gnss.sec}, F32_STEP);
				p = put(p, GN_OFF_USEC, {32'h0, raw_gnss.usec}, F32_STEP);
				p = put(p, GN_OFF_LAT, raw_gnss.lat, F64_STEP);
				p = put(p, GN_OFF_LON, raw_gnss.lon, F64_STEP);
				p = put(p, GN_OFF_HGT, raw_gnss.hgt, F64_STEP);
				for (int i = 0; i < 3; i++) begin
					p = put(p, GN_OFF_VEL + i * F32_STEP, {32'h0, raw_gnss.vel[i]}, F32_STEP);
					p = put(p, GN_OFF_SD + i * F32_STEP, {32'h0, raw_gnss.pos_sd[i]}, F32_STEP);
				end
				p = put(p, GN_OFF_TILT, {32'h0, raw_gnss.tilt}, F32_STEP);
				p = put(p, GN_OFF_HEAD, {32'h0, raw_gnss.heading}, F32_STEP);
				p = put(p, GN_OFF_TILT_SD, {32'h0, raw_gnss.tilt_sd}, F32_STEP);
				p = put(p, GN_OFF_HEAD_SD, {32'h0, raw_gnss.heading_sd}, F32_STEP);
				p = put(p, GN_OFF_STAT, {48'h0, gnss_status(raw_gnss.flags)}, 2);
			end
			ID_SATS: begin
				p = put(p, SA_OFF_HDIL, {32'h0, sats.horizontal_dilution}, F32_STEP);
				p = put(p, SA_OFF_VDIL, {32'h0, sats.vertical_dilution}, F32_STEP);
				for (int i = 0; i < 5; i++) begin
					p = put(p, SA_OFF_CNT + i, {56'h0, sats.count[i]}, 1);
				end
			end
			ID_GEODETIC, ID_ECEF, ID_GRID: begin
				// Three position doubles share one layout across the three packets
				for (int i = 0; i < 3; i++) begin
					if (id == ID_GEODETIC) begin
						p = put(p, POS_OFF_AXIS + i * F64_STEP, geodetic.axis[i], F64_STEP);
					end else if (id == ID_ECEF) begin
						p = put(p, POS_OFF_AXIS + i * F64_STEP, ecef.axis[i], F64_STEP);
					end else begin
						p = put(p, POS_OFF_AXIS + i * F64_STEP, grid.axis[i], F64_STEP);
					end
				end
				if (id == ID_GRID) begin
					p = put(p, GR_OFF_ZONE, {56'h0, grid.zone}, 1);
					p = put(p, GR_OFF_ZCHR, {56'h0, grid.zone_char}, 1);
				end
			end
			ID_NED_VEL: begin
				for (int i = 0; i < 3; i++) begin
					p = put(p, NED_OFF_VEL + i * F32_STEP, {32'h0, ned_vel.vel[i]}, F32_STEP);
				end
			end
			default: p = '0;
		endcase
		return p;
	endfunction

	// Expands byte strobes into a bit mask
	function automatic logic [31:0] strb_mask(logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i * 8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	npf_state_e state_q;
	npf_pay_t buf_q;
	logic [7:0] remain_q;
	logic [7:0] len_q;
	logic [7:0] cur_id_q;
	logic first_q;
	logic last_q;
	logic [7:0] ctrl_id_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [31:0] sent_q;
	logic aw_hold_q;
	logic w_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_mask;
	logic sw_start;
	logic start_any;
	logic [7:0] start_id;
	logic [7:0] start_len;
	logic accept;
	logic refuse;
	logic beat_taken;
	logic done;
	logic [7:0] rd_addr;

	// Write path: address and data are taken independently, the write fires once both are held
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign wr_fire = aw_hold_q && w_hold_q;
	assign wr_addr = 8'(awaddr_q) & 8'hfc;
	assign wr_mask = strb_mask(wstrb_q);
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped offsets answer with a decode error and change nothing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			case (wr_addr)
				REG_CTRL, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK, REG_SENT: bresp_q <= RESP_OKAY;
				default: bresp_q <= RESP_DECERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Control and mask registers; the start bit is a self-clearing command, not stored
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_id_q <= CTRL_ID_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr_fire) begin
			if (wr_addr == REG_CTRL && wstrb_q[0]) begin
				ctrl_id_q <= wdata_q[7:0];
			end
			if (wr_addr == REG_IRQ_MASK) begin
				irq_mask_q <= (irq_mask_q & ~wr_mask[IRQ_W-1:0]) | (wdata_q[IRQ_W-1:0] & wr_mask[IRQ_W-1:0]);
			end
		end
	end

	// Request arbitration: a register start wins over the request port in the same cycle
	assign sw_start = wr_fire && wr_addr == REG_CTRL && wstrb_q[1] && wdata_q[CTRL_START_BIT];
	assign req_ready = state_q == ST_IDLE && !sw_start;
	assign start_any = sw_start || (req_valid && req_ready);
	assign start_id = sw_start ? wdata_q[7:0] : req_id;
	assign start_len = len_of(start_id);
	// Unknown identifiers and starts during a packet are dropped and flagged
	assign accept = start_any && state_q == ST_IDLE && start_len != 8'h00;
	assign refuse = start_any && !accept;

	// Payload snapshot and byte shifter; the snapshot keeps a packet coherent while it drains
	assign beat_taken = state_q == ST_SEND && out_ready;
	assign done = beat_taken && last_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			buf_q <= '0;
			remain_q <= 8'h00;
			len_q <= 8'h00;
			cur_id_q <= 8'h00;
			first_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (accept) begin
						state_q <= ST_SEND;
						buf_q <= build(start_id);
						remain_q <= start_len;
						len_q <= start_len;
						cur_id_q <= start_id;
						first_q <= 1'b1;
						last_q <= 1'b0;
					end
				end
				ST_SEND: begin
					if (beat_taken) begin
						buf_q <= buf_q >> 8;
						remain_q <= remain_q - 8'h01;
						first_q <= 1'b0;
						last_q <= remain_q == 8'h02;
						if (last_q) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Output stream; payload is produced only, nothing on this port writes back into a packet
	assign out_valid = state_q == ST_SEND;
	assign out_beat.data = buf_q[7:0];
	assign out_beat.id = cur_id_q;
	assign out_beat.first = first_q;
	assign out_beat.last = last_q;
	assign out_len = len_q;

	// Sticky event bits: a new event in the clearing cycle survives the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= '0;
		end else begin
			logic [IRQ_W-1:0] clr;
			logic [IRQ_W-1:0] set;
			clr = '0;
			set = '0;
			if (wr_fire && wr_addr == REG_IRQ_STAT) begin
				clr = wdata_q[IRQ_W-1:0] & wr_mask[IRQ_W-1:0];
			end
			set[IRQ_DONE_BIT] = done;
			set[IRQ_REFUSED_BIT] = refuse;
			irq_stat_q <= (irq_stat_q & ~clr) | set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// Completed packet count, wraps at the top
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sent_q <= 32'h0;
		end else if (done) begin
			sent_q <= sent_q + 32'h1;
		end
	end

	// Read path: one read outstanding, answered the cycle after the address is taken
	assign s_axi_arready = !rvalid_q;
	assign rd_addr = 8'(s_axi_araddr) & 8'hfc;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0;
			case (rd_addr)
				REG_CTRL: rdata_q[7:0] <= ctrl_id_q;
				REG_STATUS: begin
					rdata_q[STAT_BUSY_BIT] <= state_q == ST_SEND;
					rdata_q[STAT_ID_LSB +: 8] <= cur_id_q;
					rdata_q[STAT_REM_LSB +: 8] <= remain_q;
				end
				REG_IRQ_STAT: rdata_q[IRQ_W-1:0] <= irq_stat_q;
				REG_IRQ_MASK: rdata_q[IRQ_W-1:0] <= irq_mask_q;
				REG_SENT: rdata_q <= sent_q;
				default: rresp_q <= RESP_DECERR;
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- rtl/npf_pkg.sv
// Package for the navigation packet payload formatter: identifiers, layouts, registers
`default_nettype none
package npf_pkg;

	// Payload buffer sized for the longest packet
	localparam int PAY_MAX = 74;
	localparam int PAY_W = PAY_MAX * 8;
	typedef logic [PAY_W-1:0] npf_pay_t;

	// Packet identifiers
	localparam logic [7:0] ID_RAW_SENSOR = 8'h1c;
	localparam logic [7:0] ID_RAW_GNSS = 8'h1d;
	localparam logic [7:0] ID_SATS = 8'h1e;
	localparam logic [7:0] ID_GEODETIC = 8'h20;
	localparam logic [7:0] ID_ECEF = 8'h21;
	localparam logic [7:0] ID_GRID = 8'h22;
	localparam logic [7:0] ID_NED_VEL = 8'h23;

	// Payload lengths in bytes
	localparam logic [7:0] LEN_RAW_SENSOR = 8'h30;
	localparam logic [7:0] LEN_RAW_GNSS = 8'h4a;
	localparam logic [7:0] LEN_SATS = 8'h0d;
	localparam logic [7:0] LEN_GEODETIC = 8'h18;
	localparam logic [7:0] LEN_ECEF = 8'h18;
	localparam logic [7:0] LEN_GRID = 8'h1a;
	localparam logic [7:0] LEN_NED_VEL = 8'h0c;

	// Field byte offsets
	localparam int RS_OFF_ACC = 0, RS_OFF_GYR = 12, RS_OFF_MAG = 24;
	localparam int RS_OFF_IMU_T = 36, RS_OFF_PRES = 40, RS_OFF_PRES_T = 44;
	localparam int GN_OFF_SEC = 0, GN_OFF_USEC = 4, GN_OFF_LAT = 8, GN_OFF_LON = 16, GN_OFF_HGT = 24;
	localparam int GN_OFF_VEL = 32, GN_OFF_SD = 44, GN_OFF_TILT = 56, GN_OFF_HEAD = 60;
	localparam int GN_OFF_TILT_SD = 64, GN_OFF_HEAD_SD = 68, GN_OFF_STAT = 72;
	localparam int SA_OFF_HDIL = 0, SA_OFF_VDIL = 4, SA_OFF_CNT = 8;
	localparam int POS_OFF_AXIS = 0, GR_OFF_ZONE = 24, GR_OFF_ZCHR = 25, NED_OFF_VEL = 0;
	localparam int F32_STEP = 4, F64_STEP = 8;

	// Receiver condition flags; the status word is assembled from these
	typedef struct packed {
		logic gnss2_fail;
		logic gnss1_fail;
		logic ant2_short;
		logic ant1_short;
		logic ant2_disc;
		logic ant1_disc;
		logic float_amb;
		logic heading_valid;
		logic tilt_valid;
		logic ext_rx;
		logic time_valid;
		logic doppler_valid;
		logic [2:0] fix;
	} npf_gnss_flags_s;

	typedef struct packed {
		logic [2:0][31:0] acc;
		logic [2:0][31:0] gyr;
		logic [2:0][31:0] mag;
		logic [31:0] imu_temp;
		logic [31:0] pressure;
		logic [31:0] pres_temp;
	} npf_raw_sensor_s;

	typedef struct packed {
		logic [31:0] sec;
		logic [31:0] usec;
		logic [63:0] lat;
		logic [63:0] lon;
		logic [63:0] hgt;
		logic [2:0][31:0] vel;
		logic [2:0][31:0] pos_sd;
		logic [31:0] tilt;
		logic [31:0] heading;
		logic [31:0] tilt_sd;
		logic [31:0] heading_sd;
		npf_gnss_flags_s flags;
	} npf_gnss_s;

	typedef struct packed {
		logic [31:0] horizontal_dilution;
		logic [31:0] vertical_dilution;
		logic [4:0][7:0] count;
	} npf_sats_s;

	typedef struct packed {
		logic [2:0][63:0] axis;
	} npf_pos_s;

	typedef struct packed {
		logic [2:0][63:0] axis;
		logic [7:0] zone;
		logic [7:0] zone_char;
	} npf_grid_s;

	typedef struct packed {
		logic [2:0][31:0] vel;
	} npf_ned_s;

	// One byte of the outgoing payload stream
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] id;
		logic first;
		logic last;
	} npf_beat_s;

	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_SENT = 8'h10;
	localparam int CTRL_START_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ID_LSB = 8;
	localparam int STAT_REM_LSB = 16;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_REFUSED_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [7:0] CTRL_ID_RST = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SEND = 2'h1
	} npf_state_e;

endpackage
`default_nettype wire

//--- verif/npf_host_sink.sv
// Host-side sink that takes the payload stream, stalling at random when asked
`default_nettype none
module npf_host_sink (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic out_valid,
	input wire npf_pkg::npf_beat_s out_beat,
	output var logic out_ready
);
	import npf_pkg::*;
	npf_beat_s got[$];
	int seed = 32'hc455;

	// Ready drops at random while slow, so stalls land anywhere in a packet
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= !slow || (($random(seed) & 1) == 0);
		end
	end

	// Bytes kept in arrival order; fields are read low byte first
	always @(posedge clk) begin
		if (nrst && out_valid && out_ready) begin
			got.push_back(out_beat);
		end
	end
endmodule
`default_nettype wire

//--- verif/npf_payload_formatter_properties.sv
// Checker for the formatter's bus answers, packet requests and byte stream
`default_nettype none
module npf_payload_formatter_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic req_valid,
	input wire logic [7:0] req_id,
	input wire logic req_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire npf_pkg::npf_beat_s out_beat,
	input wire logic [7:0] out_len,
	input wire logic irq
);
	import npf_pkg::*;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Documented length of a known packet; zero marks an unknown identifier
	function automatic logic [7:0] len_of(input logic [7:0] id);
		case (id)
			ID_RAW_SENSOR: return LEN_RAW_SENSOR;
			ID_RAW_GNSS: return LEN_RAW_GNSS;
			ID_SATS: return LEN_SATS;
			ID_GEODETIC: return LEN_GEODETIC;
			ID_ECEF: return LEN_ECEF;
			ID_GRID: return LEN_GRID;
			ID_NED_VEL: return LEN_NED_VEL;
			default: return 8'h00;
		endcase
	endfunction

	// Bytes taken so far in this packet; restarts after the last one
	assign cnt_d = (out_valid && out_ready) ? (out_beat.last ? 8'h00 : cnt_q + 8'h01) : cnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	start_beat_a: assert property (
		req_valid && req_ready && len_of(req_id) != 8'h00 |=> out_valid && out_beat.first && out_beat.id == $past(req_id))
		else $error("accepted packet did not start");
	refused_id_a: assert property (req_valid && req_ready && len_of(req_id) == 8'h00 |=> !out_valid)
		else $error("unknown packet streamed");
	packet_len_a: assert property (out_valid && out_beat.first |-> out_len == len_of(out_beat.id))
		else $error("payload length wrong");
	last_byte_a: assert property (out_valid |-> out_beat.last == ((cnt_q + 8'h01) == out_len))
		else $error("last flag misplaced");
	beat_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
		else $error("byte changed while stalled");
	gap_free_a: assert property (
		out_valid && out_ready && !out_beat.last |=> out_valid && !out_beat.first && $stable(out_beat.id))
		else $error("gap inside packet");
	rsvd_zero_a: assert property (out_valid && out_beat.id == ID_RAW_GNSS && cnt_q == 8'h49 |-> !out_beat.data[1])
		else $error("reserved status bit set");
	busy_block_a: assert property (out_valid |-> !req_ready)
		else $error("request open while streaming");

	cover property (req_valid && req_ready);
	cover property (out_valid && !out_ready);
	cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
	cover property ($rose(irq));
endmodule
bind npf_payload_formatter npf_payload_formatter_checker u_npf_payload_formatter_checker (.clk, .nrst,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .req_valid, .req_id, .req_ready, .out_valid, .out_ready, .out_beat, .out_len, .irq);
`default_nettype wire

//--- verif/tb_npf_payload_formatter.sv
// Self-checking bench: register bus, packet requests, payload bytes and interrupt
`default_nettype none
module tb_npf_payload_formatter;
	timeunit 1ns;
	timeprecision 1ps;
	import npf_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, slow = 1'b0, req_valid = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready, out_valid, out_ready, irq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, req_id = 8'h00, out_len;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	npf_raw_sensor_s raw_sensor = '0;
	npf_gnss_s raw_gnss = '0;
	npf_sats_s sats = '0;
	npf_pos_s geodetic = '0, ecef = '0;
	npf_grid_s grid = '0;
	npf_ned_s ned_vel = '0;
	npf_beat_s out_beat;
	logic [7:0] exp_q[$];
	logic [7:0] ids[7] = '{ID_RAW_SENSOR, ID_RAW_GNSS, ID_SATS, ID_GEODETIC, ID_ECEF, ID_GRID, ID_NED_VEL};
	logic [7:0] lens[7] = '{8'h30, 8'h4a, 8'h0d, 8'h18, 8'h18, 8'h1a, 8'h0c};
	int num_errors = 0, num_checks = 0, seed = 32'hc455;

	npf_payload_formatter u_npf_payload_formatter (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.req_valid, .req_id, .req_ready, .raw_sensor, .raw_gnss, .sats, .geodetic, .ecef, .grid, .ned_vel,
		.out_valid, .out_ready, .out_beat, .out_len, .irq);
	npf_host_sink u_npf_host_sink (.clk, .nrst, .slow, .out_valid, .out_beat, .out_ready);

	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic tmo();
		num_errors++;
		$display("[FAIL] %0t wait ran out %h %h", $time, 1'b0, 1'b1);
		finish_test();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	// Write one word; response kept in rs
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n > 100) tmo();
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read one word into rd, response into rs
	task automatic axr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n > 100) tmo();
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic put(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++) exp_q.push_back(v[8*i+:8]);
	endtask

	// Expected payload, little-endian fields at their listed offsets
	task automatic build(input logic [7:0] id);
		exp_q.delete();
		case (id)
			ID_RAW_SENSOR: begin
				for (int i = 0; i < 9; i++) put(i < 3 ? raw_sensor.acc[i] : i < 6 ? raw_sensor.gyr[i-3] : raw_sensor.mag[i-6], 4);
				put(raw_sensor.imu_temp, 4);
				put(raw_sensor.pressure, 4);
				put(raw_sensor.pres_temp, 4);
			end
			ID_RAW_GNSS: begin
				put({raw_gnss.usec, raw_gnss.sec}, 8);
				for (int i = 0; i < 3; i++) put(i == 0 ? raw_gnss.lat : i == 1 ? raw_gnss.lon : raw_gnss.hgt, 8);
				for (int i = 0; i < 6; i++) put(i < 3 ? raw_gnss.vel[i] : raw_gnss.pos_sd[i-3], 4);
				put({raw_gnss.heading, raw_gnss.tilt}, 8);
				put({raw_gnss.heading_sd, raw_gnss.tilt_sd}, 8);
				put({raw_gnss.flags[14:9], 1'b0, raw_gnss.flags[8:0]}, 2);
			end
			ID_SATS: begin
				put({sats.vertical_dilution, sats.horizontal_dilution}, 8);
				for (int i = 0; i < 5; i++) put(sats.count[i], 1);
			end
			ID_GEODETIC, ID_ECEF: for (int i = 0; i < 3; i++) put(id == ID_ECEF ? ecef.axis[i] : geodetic.axis[i], 8);
			ID_GRID: begin
				for (int i = 0; i < 3; i++) put(grid.axis[i], 8);
				put({grid.zone_char, grid.zone}, 2);
			end
			default: for (int i = 0; i < 3; i++) put(ned_vel.vel[i], 4);
		endcase
	endtask

	// Fresh random field values on every input struct
	task automatic rnd_in();
		logic [1023:0] r;
		for (int i = 0; i < 32; i++) r[32*i+:32] = $random(seed);
		raw_sensor <= npf_raw_sensor_s'(r);
		raw_gnss <= npf_gnss_s'(r >> 5);
		sats <= npf_sats_s'(r >> 9);
		geodetic <= npf_pos_s'(r >> 13);
		ecef <= npf_pos_s'(r >> 17);
		grid <= npf_grid_s'(r >> 21);
		ned_vel <= npf_ned_s'(r >> 25);
	endtask

	// One packet end to end; inputs change after acceptance to prove the snapshot
	task automatic pkt(input int k, input bit viareg);
		int n;
		rnd_in();
		@(posedge clk);
		build(ids[k]);
		u_npf_host_sink.got.delete();
		n = 0;
		if (viareg) begin
			axw(REG_CTRL, {23'h0, 1'b1, ids[k]}, 4'h3);
		end else begin
			req_id <= ids[k];
			req_valid <= 1'b1;
			do begin
				@(posedge clk);
				n++;
			end while (!req_ready && n < 100);
			req_valid <= 1'b0;
		end
		rnd_in();
		while (u_npf_host_sink.got.size() < exp_q.size() && n < 500) begin
			@(posedge clk);
			n++;
		end
		if (n >= 500) tmo();
		@(posedge clk);
		chk(u_npf_host_sink.got.size(), lens[k]);
		chk(out_len, lens[k]);
		chk(out_valid, 1'b0);
		foreach (exp_q[i]) begin
			chk(u_npf_host_sink.got[i].data, exp_q[i]);
			chk({u_npf_host_sink.got[i].id, u_npf_host_sink.got[i].first, u_npf_host_sink.got[i].last},
				{ids[k], i == 0, i == lens[k] - 1});
		end
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		axr(REG_CTRL);
		chk(rd[8:0], 9'h0);
		axr(REG_IRQ_MASK);
		chk(rd[1:0], IRQ_MASK_RST);
		axw(8'h40, $random(seed), 4'hf);
		chk(rs, RESP_DECERR);
		axr(8'h40);
		chk(rd, 32'h0);
		chk(rs, RESP_DECERR);
		axw(REG_IRQ_MASK, 32'h3, 4'hf);
		chk(rs, RESP_OKAY);
		for (int k = 0; k < 7; k++) begin
			slow <= 1'($random(seed));
			pkt(k, k == 6);
		end
		chk(irq, 1'b1);
		axr(REG_CTRL);
		chk(rd[8:0], {1'b0, ID_NED_VEL});
		axr(REG_SENT);
		chk(rd, 32'h7);
		axw(REG_IRQ_STAT, 32'h1, 4'hf);
		chk(irq, 1'b0);
		slow <= 1'b1;
		fork
			pkt(1, 1'b0);
			begin
				repeat (12) @(posedge clk);
				axw(REG_CTRL, {23'h0, 1'b1, ID_NED_VEL}, 4'h3);
			end
		join
		axr(REG_IRQ_STAT);
		chk(rd[1:0], 2'h3);
		axw(REG_IRQ_STAT, 32'h3, 4'hf);
		req_id <= 8'h1f;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (2) @(posedge clk);
		chk(out_valid, 1'b0);
		axr(REG_IRQ_STAT);
		chk(rd[1:0], 2'h2);
		axw(REG_IRQ_STAT, 32'h3, 4'hf);
		axw(REG_IRQ_MASK, 32'h0, 4'hf);
		pkt(0, 1'b0);
		chk(irq, 1'b0);
		axr(REG_IRQ_STAT);
		chk(rd[1:0], 2'h1);
		// Idle status after the last packet: not busy, last id kept, nothing left to send
		axr(REG_STATUS);
		chk(rd, {16'h0, ID_RAW_SENSOR, 8'h00});
		chk(rs, RESP_OKAY);
		finish_test();
	end
endmodule
`default_nettype wire
